//--- rtl/ctu_charge_time_unit.sv
// Our own choices: register access over Wishbone and the placing of the registers.
`timescale 1ns/1ps
`default_nettype none
// Behaviour
// - Unit works only while control bit 15 is set, except the bit 9 ground control and software clearing of edge flags, which act at all times.
// - With bit 13 set the unit halts while the device idles.
// - Bit 12 turns edge delay generation on and off.
// - Bit 11 picks hardware edges; clear means software writes edge flags.
// - Bit 10 makes edge 2 wait until edge 1 has occurred.
// - Bit 9 grounds the current source output.
// - Bit 8 lets edge 2 trigger an ADC conversion; clear never triggers.
// - Bit 14 and bits 7-0 ignore writes and read zero.
// - Hold capacitor discharge only through the ground control.
module ctu_charge_time_unit
    import ctu_pkg::*;
(
    // Clock and reset
    input wire logic clk_i,
    input wire logic rst_i,
    // Wishbone slave
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [ADDR_W-1:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    // Device state and edge sources
    input wire logic idle_mode_i,
    input wire logic hw_edge1_i,
    input wire logic hw_edge2_i,
    // Analog and ADC controls
    output logic unit_active_o,
    output logic delay_gen_o,
    output logic current_on_o,
    output logic source_ground_o,
    output logic adc_trigger_o,
    output logic [1:0] edge_flags_o
);

    ctu_ctrl_type ctrl_ff;
    logic ack_ff;
    logic [31:0] dat_ff;
    logic active_ff;
    logic delay_ff;
    logic current_ff;
    logic ground_ff;
    logic trig_ff;
    logic req;
    logic wr_ctrl;
    logic wr_stat;
    logic active;
    logic [15:0] ctrl_word;
    logic [1:0] flags;
    logic take2;
    logic [31:0] nxt_dat;

    // ************************************************************
    // Bus decode
    // ************************************************************
    assign req = wb_cyc_i && wb_stb_i && !ack_ff;
    assign wr_ctrl = req && wb_we_i && (wb_adr_i == CTRL_OFS) && wb_sel_i[1];
    assign wr_stat = req && wb_we_i && (wb_adr_i == STAT_OFS) && wb_sel_i[0];

    always_comb begin
        ctrl_word = 16'h0000;
        ctrl_word[UNIT_EN_BIT] = ctrl_ff.unit_enable;
        ctrl_word[IDLE_STOP_BIT] = ctrl_ff.idle_stop;
        ctrl_word[DELAY_GEN_BIT] = ctrl_ff.delay_generation_enable;
        ctrl_word[HW_EDGE_BIT] = ctrl_ff.hardware_edge_enable;
        ctrl_word[EDGE_ORDER_BIT] = ctrl_ff.edge_order_enable;
        ctrl_word[SRC_GND_BIT] = ctrl_ff.source_ground_enable;
        ctrl_word[CONV_TRIG_BIT] = ctrl_ff.conversion_trigger_enable;
        nxt_dat = 32'h0000_0000;
        if (wb_adr_i == CTRL_OFS) begin
            nxt_dat = {16'h0000, ctrl_word & CTRL_IMPL_MASK};
        end else if (wb_adr_i == STAT_OFS) begin
            nxt_dat = {30'h0000_0000, flags};
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ack_ff <= 1'b0;
            dat_ff <= 32'h0000_0000;
        end else begin
            ack_ff <= req;
            if (req && !wb_we_i) begin
                dat_ff <= nxt_dat;
            end
        end
    end

    // ************************************************************
    // Control register
    // ************************************************************
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ctrl_ff <= CTRL_STRUCT_RST;
        end else if (wr_ctrl) begin
            // Only the upper lane holds implemented bits
            ctrl_ff.unit_enable <= wb_dat_i[UNIT_EN_BIT];
            ctrl_ff.idle_stop <= wb_dat_i[IDLE_STOP_BIT];
            ctrl_ff.delay_generation_enable <= wb_dat_i[DELAY_GEN_BIT];
            ctrl_ff.hardware_edge_enable <= wb_dat_i[HW_EDGE_BIT];
            ctrl_ff.edge_order_enable <= wb_dat_i[EDGE_ORDER_BIT];
            ctrl_ff.source_ground_enable <= wb_dat_i[SRC_GND_BIT];
            ctrl_ff.conversion_trigger_enable <= wb_dat_i[CONV_TRIG_BIT];
        end
    end

    // ************************************************************
    // Run control and edge logic
    // ************************************************************
    assign active = ctrl_ff.unit_enable && !(ctrl_ff.idle_stop && idle_mode_i);

    ctu_edge_seq u_edge_seq (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .active_i(active),
        .hw_en_i(ctrl_ff.hardware_edge_enable),
        .order_en_i(ctrl_ff.edge_order_enable),
        .hw_edge1_i(hw_edge1_i),
        .hw_edge2_i(hw_edge2_i),
        .sw_wr_i(wr_stat),
        .sw_data_i(wb_dat_i[1:0]),
        .flags_o(flags),
        .edge2_take_o(take2)
    );

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            active_ff <= 1'b0;
            delay_ff <= 1'b0;
            current_ff <= 1'b0;
        end else begin
            active_ff <= active;
            delay_ff <= active && ctrl_ff.delay_generation_enable;
            current_ff <= active && flags[EDGE1_BIT] && !flags[EDGE2_BIT];
        end
    end

    // Grounding has no automatic path; it follows the bit alone
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ground_ff <= 1'b0;
        end else begin
            ground_ff <= ctrl_ff.source_ground_enable;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            trig_ff <= 1'b0;
        end else begin
            trig_ff <= take2 && ctrl_ff.conversion_trigger_enable;
        end
    end

    assign wb_ack_o = ack_ff;
    assign wb_dat_o = dat_ff;
    assign unit_active_o = active_ff;
    assign delay_gen_o = delay_ff;
    assign current_on_o = current_ff;
    assign source_ground_o = ground_ff;
    assign adc_trigger_o = trig_ff;
    assign edge_flags_o = flags;

    // ************************************************************
    // Assertions
    // ************************************************************
    a_enable_gates_active: assert property (@(posedge clk_i) disable iff (rst_i)
        !ctrl_ff.unit_enable |=> !unit_active_o)
        else $error("Unit active while disabled");

    a_flags_hold_disabled: assert property (@(posedge clk_i) disable iff (rst_i)
        (!ctrl_ff.unit_enable && !wr_stat) |=> ($past(flags) == flags))
        else $error("Edge flag set while disabled");

    a_idle_stop_halts: assert property (@(posedge clk_i) disable iff (rst_i)
        (ctrl_ff.unit_enable && ctrl_ff.idle_stop && idle_mode_i) |=> !unit_active_o)
        else $error("Unit kept running in idle with stop set");

    a_idle_keeps_running: assert property (@(posedge clk_i) disable iff (rst_i)
        (ctrl_ff.unit_enable && !ctrl_ff.idle_stop) |=> unit_active_o)
        else $error("Unit halted without idle stop");

    a_delay_follows_bit: assert property (@(posedge clk_i) disable iff (rst_i)
        active |=> (delay_gen_o == $past(ctrl_ff.delay_generation_enable)))
        else $error("Delay generation does not follow its bit");

    a_sw_edge_sets_flag: assert property (@(posedge clk_i) disable iff (rst_i)
        (active && !ctrl_ff.hardware_edge_enable && wr_stat && wb_dat_i[EDGE1_BIT])
        |=> flags[EDGE1_BIT])
        else $error("Software edge 1 not recorded");

    a_hw_mode_no_sw_set: assert property (@(posedge clk_i) disable iff (rst_i)
        (ctrl_ff.hardware_edge_enable && !flags[EDGE1_BIT] && !hw_edge1_i)
        |=> !flags[EDGE1_BIT])
        else $error("Edge 1 set without hardware edge");

    a_order_blocks_edge2: assert property (@(posedge clk_i) disable iff (rst_i)
        (ctrl_ff.edge_order_enable && $past(ctrl_ff.edge_order_enable) && !flags[EDGE1_BIT]
        && !$past(flags[EDGE1_BIT])) |-> !take2)
        else $error("Edge 2 taken before edge 1");

    a_ground_follows_bit: assert property (@(posedge clk_i) disable iff (rst_i)
        ##1 (source_ground_o == $past(ctrl_ff.source_ground_enable)))
        else $error("Ground output does not follow its bit");

    a_trigger_needs_bit: assert property (@(posedge clk_i) disable iff (rst_i)
        adc_trigger_o |-> ($past(take2) && $past(ctrl_ff.conversion_trigger_enable)))
        else $error("ADC trigger without cause");

    a_trigger_on_edge2: assert property (@(posedge clk_i) disable iff (rst_i)
        (take2 && ctrl_ff.conversion_trigger_enable) |=> adc_trigger_o)
        else $error("ADC trigger missing after edge 2");

    a_unimpl_read_zero: assert property (@(posedge clk_i) disable iff (rst_i)
        (req && !wb_we_i && wb_adr_i == CTRL_OFS) |=> (wb_dat_o[31:0] & ~{16'h0000,
        CTRL_IMPL_MASK}) == 32'h0000_0000)
        else $error("Unimplemented control bits read nonzero");

    a_reset_clears_ctrl: assert property (@(posedge clk_i)
        rst_i |=> (ctrl_ff == CTRL_STRUCT_RST && !adc_trigger_o))
        else $error("Control bits not cleared by reset");

endmodule // ctu_charge_time_unit
`default_nettype wire

//--- common/ctu_pkg.sv
package ctu_pkg;

    // ************************************************************
    // Register map
    // ************************************************************
    localparam int ADDR_W = 8;
    localparam logic [ADDR_W-1:0] CTRL_OFS = 8'h00;
    localparam logic [ADDR_W-1:0] STAT_OFS = 8'h04;

    // ************************************************************
    // Control register fields
    // ************************************************************
    localparam int UNIT_EN_BIT = 15;
    localparam int IDLE_STOP_BIT = 13;
    localparam int DELAY_GEN_BIT = 12;
    localparam int HW_EDGE_BIT = 11;
    localparam int EDGE_ORDER_BIT = 10;
    localparam int SRC_GND_BIT = 9;
    localparam int CONV_TRIG_BIT = 8;
    localparam logic [15:0] CTRL_IMPL_MASK = 16'hBF00;
    localparam logic [15:0] CTRL_RST = 16'h0000;

    // ************************************************************
    // Edge status fields
    // ************************************************************
    localparam int EDGE1_BIT = 0;
    localparam int EDGE2_BIT = 1;
    localparam logic [1:0] FLAGS_RST = 2'h0;

    typedef struct packed {
        logic unit_enable;
        logic idle_stop;
        logic delay_generation_enable;
        logic hardware_edge_enable;
        logic edge_order_enable;
        logic source_ground_enable;
        logic conversion_trigger_enable;
    } ctu_ctrl_type;

    localparam ctu_ctrl_type CTRL_STRUCT_RST = '{default: 1'b0};

endpackage

//--- rtl/ctu_edge_seq.sv
`timescale 1ns/1ps
`default_nettype none
module ctu_edge_seq
    import ctu_pkg::*;
(
    // Clock and reset
    input wire logic clk_i,
    input wire logic rst_i,
    // Control
    input wire logic active_i,
    input wire logic hw_en_i,
    input wire logic order_en_i,
    // Edge sources
    input wire logic hw_edge1_i,
    input wire logic hw_edge2_i,
    input wire logic sw_wr_i,
    input wire logic [1:0] sw_data_i,
    // Results
    output logic [1:0] flags_o,
    output logic edge2_take_o
);

    logic [1:0] hw_prev_ff;
    logic [1:0] flags_ff;
    logic take2_ff;
    logic [1:0] hw_rise;
    logic [1:0] ev;
    logic [1:0] nxt_flags;

    // ************************************************************
    // Event selection
    // ************************************************************
    always_comb begin
        hw_rise = {hw_edge2_i, hw_edge1_i} & ~hw_prev_ff;
        if (hw_en_i) begin
            ev = hw_rise;
        end else begin
            ev = {2{sw_wr_i}} & sw_data_i & ~flags_ff;
        end
        ev = ev & {2{active_i}};
        if (order_en_i && !flags_ff[EDGE1_BIT] && !ev[EDGE1_BIT]) begin
            ev[EDGE2_BIT] = 1'b0;
        end
        // Hardware set wins over a software clear
        nxt_flags = ev | (flags_ff & ~({2{sw_wr_i}} & ~sw_data_i));
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            hw_prev_ff <= 2'h0;
        end else begin
            hw_prev_ff <= {hw_edge2_i, hw_edge1_i};
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            flags_ff <= FLAGS_RST;
            take2_ff <= 1'b0;
        end else begin
            flags_ff <= nxt_flags;
            take2_ff <= ev[EDGE2_BIT];
        end
    end

    assign flags_o = flags_ff;
    assign edge2_take_o = take2_ff;

endmodule // ctu_edge_seq
`default_nettype wire

//--- tb/ctu_edge_src.sv
`timescale 1ns/1ps
`default_nettype none
module ctu_edge_src (
    // Clock and reset
    input wire logic clk_i,
    input wire logic rst_i,
    // Bench commands
    input wire logic fire1_i,
    input wire logic fire2_i,
    // From the unit
    input wire logic adc_trigger_i,
    input wire logic source_ground_i,
    // To the unit and bench
    output logic hw_edge1_o,
    output logic hw_edge2_o,
    output logic cap_clear_o,
    output logic [7:0] trig_count_o
);
    // ************
    // Edge sources
    // ************
    always_ff @(posedge clk_i) begin
        hw_edge1_o <= fire1_i & ~rst_i;
        hw_edge2_o <= fire2_i & ~rst_i;
    end
    // ************
    // ADC side
    // ************
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            trig_count_o <= 8'h00;
        end else if (adc_trigger_i) begin
            trig_count_o <= trig_count_o + 8'h01;
        end
    end
    // Capacitor cleared while grounded; no discharge otherwise
    assign cap_clear_o = source_ground_i;
endmodule // ctu_edge_src
`default_nettype wire

//--- tb/tb_charge_time_edge_control.sv
`timescale 1ns/1ps
`default_nettype none
module tb_charge_time_edge_control;
    import ctu_pkg::*;
    logic clk_i = 0, rst_i = 1, cyc = 0, stb = 0, we = 0, idle = 0, f1 = 0, f2 = 0;
    logic [7:0] adr = 8'h00;
    logic [3:0] sel = 4'h0;
    logic [31:0] dat = 32'h0, rdat, q;
    logic ack, act, dly, cur, gnd, trg, e1, e2, cap;
    logic [1:0] flg;
    logic [7:0] tcnt;
    int err_count = 0, cmp_count = 0, seed = 77286, cyc_n = 0;
    ctu_charge_time_unit uut (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb),
        .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(dat), .wb_dat_o(rdat),
        .wb_ack_o(ack), .idle_mode_i(idle), .hw_edge1_i(e1), .hw_edge2_i(e2),
        .unit_active_o(act), .delay_gen_o(dly), .current_on_o(cur), .source_ground_o(gnd),
        .adc_trigger_o(trg), .edge_flags_o(flg));
    ctu_edge_src far (.clk_i(clk_i), .rst_i(rst_i), .fire1_i(f1), .fire2_i(f2),
        .adc_trigger_i(trg), .source_ground_i(gnd), .hw_edge1_o(e1), .hw_edge2_o(e2),
        .cap_clear_o(cap), .trig_count_o(tcnt));
    initial begin
        forever #4 clk_i = ~clk_i;
    end
    always @(posedge clk_i) begin
        cyc_n++;
        if (cyc_n == 5000) begin
            err_count++;
            wrap_up();
        end
    end
    // ************
    // Bench tasks
    // ************
    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        cmp_count++;
        if (g !== e) begin
            err_count++;
            $display("[FAIL] %s expected %h seen %h", nm, e, g);
        end
    endtask
    task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge clk_i);
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        adr <= a;
        dat <= d;
        sel <= 4'hF;
        do begin
            @(posedge clk_i);
        end while (ack !== 1'b1);
        q = rdat;
        cyc <= 1'b0;
        stb <= 1'b0;
        we <= 1'b0;
    endtask
    task automatic fire(input logic a, input logic b);
        @(posedge clk_i);
        f1 <= a;
        f2 <= b;
        @(posedge clk_i);
        f1 <= 1'b0;
        f2 <= 1'b0;
        repeat (5) @(posedge clk_i);
    endtask
    task automatic wrap_up();
        $display("counts: compares %0d mismatches %0d", cmp_count, err_count);
        if (err_count == 0 && cmp_count > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask
    function automatic logic [31:0] ctrl_exp(input logic [31:0] w);
        return {16'h0000, w[15:0] & 16'hBF00};
    endfunction
    // ************
    // Main sequence
    // ************
    initial begin
        logic [31:0] w;
        repeat (4) @(posedge clk_i);
        rst_i <= 1'b0;
        bus(0, CTRL_OFS, 32'h0);
        chk("ctrl reset", 32'h0, q);
        bus(0, STAT_OFS, 32'h0);
        chk("stat reset", 32'h0, q);
        chk("trigger reset", 32'h0, {31'h0, trg});
        bus(1, CTRL_OFS, 32'hFFFFFFFF);
        bus(0, CTRL_OFS, 32'h0);
        chk("ctrl ones", 32'h0000BF00, q);
        for (int i = 0; i < 6; i++) begin
            w = $random(seed);
            bus(1, CTRL_OFS, w);
            bus(0, CTRL_OFS, 32'h0);
            chk("ctrl random", ctrl_exp(w), q);
        end
        bus(0, 8'h08, 32'h0);
        chk("unmapped", 32'h0, q);
        $display("test registers done");
        bus(1, STAT_OFS, 32'h0);
        bus(1, CTRL_OFS, 32'h0200);
        repeat (2) @(posedge clk_i);
        chk("ground", 32'h3, {30'h0, gnd, cap});
        bus(1, CTRL_OFS, 32'h0900);
        fire(1, 0);
        chk("disabled flags", 32'h0, {30'h0, flg});
        chk("disabled active", 32'h0, {31'h0, act});
        bus(1, CTRL_OFS, 32'h8D00);
        fire(0, 1);
        chk("edge2 first", 32'h0, {30'h0, flg});
        fire(1, 0);
        chk("edge1", 32'h1, {30'h0, flg});
        chk("charging", 32'h1, {31'h0, cur});
        fire(0, 1);
        chk("edge2", 32'h3, {30'h0, flg});
        chk("adc trigger", 32'h1, {24'h0, tcnt});
        $display("test hardware edges done");
        bus(1, STAT_OFS, 32'h0);
        bus(1, CTRL_OFS, 32'h8800);
        fire(0, 1);
        chk("no order", 32'h2, {30'h0, flg});
        chk("no trigger", 32'h1, {24'h0, tcnt});
        bus(1, STAT_OFS, 32'h3);
        bus(0, STAT_OFS, 32'h0);
        chk("hw ignores sw set", 32'h2, q);
        bus(1, STAT_OFS, 32'h0);
        bus(1, CTRL_OFS, 32'h8000);
        bus(1, STAT_OFS, 32'h1);
        repeat (2) @(posedge clk_i);
        chk("sw edge", 32'h1, {30'h0, flg});
        $display("test software edges done");
        idle <= 1'b1;
        bus(1, CTRL_OFS, 32'hB000);
        repeat (2) @(posedge clk_i);
        chk("idle stop", 32'h0, {30'h0, act, dly});
        bus(1, CTRL_OFS, 32'h9000);
        repeat (2) @(posedge clk_i);
        chk("idle run", 32'h3, {30'h0, act, dly});
        bus(1, CTRL_OFS, 32'h8000);
        repeat (2) @(posedge clk_i);
        chk("delay off", 32'h0, {31'h0, dly});
        idle <= 1'b0;
        $display("test idle and delay done");
        bus(1, CTRL_OFS, 32'h0000FFFF);
        @(posedge clk_i);
        rst_i <= 1'b1;
        repeat (2) @(posedge clk_i);
        rst_i <= 1'b0;
        bus(0, CTRL_OFS, 32'h0);
        chk("ctrl mid reset", 32'h0, q);
        bus(0, STAT_OFS, 32'h0);
        chk("stat mid reset", 32'h0, q);
        $display("test mid reset done");
        wrap_up();
    end
endmodule // tb_charge_time_edge_control
`default_nettype wire
